// [hw/usf_pkg.sv]
// constants and types of the serial status flag block
// assumes a single core clock and a plain strobe register port
package usf_pkg;
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_CTRL = 8'h02;
  localparam int B_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int B_TC = 6;
  localparam int B_RX_BUFFER_FULL_FLAG = 5;
  localparam int B_IDLE = 4;
  localparam int B_OVR = 3;
  localparam int B_NF = 2;
  localparam int B_FE = 1;
  localparam int B_PF = 0;
  localparam logic [7:0] STATUS_RESET = 8'hc0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CLR_ON_WRITE = 8'hc0;
  localparam logic [7:0] CLR_ON_READ = 8'h3f;
  localparam logic [7:0] CLR_TC = 8'h40;
  localparam logic [7:0] ARM_ALWAYS = 8'h05;
  localparam int C_BRK = 0;
  localparam int C_TXON = 1;
  localparam int C_PKIND = 2;
  localparam int C_PEN = 3;
  localparam int C_ILT = 4;
  localparam int C_NINE = 5;
  localparam int C_LONG_BREAK_DETECT_ENABLE = 6;
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] STOP_END = 4'ha;
  localparam logic [3:0] DATA_S_FIRST = 4'h7;
  localparam logic [3:0] DATA_S_LAST = 4'h9;
  localparam logic [3:0] START_S_A = 4'h3;
  localparam logic [3:0] START_S_B = 4'h5;
  localparam logic [3:0] START_S_LAST = 4'hb;
  localparam logic [3:0] CHAR_BITS_8 = 4'ha;
  localparam logic [3:0] CHAR_BITS_9 = 4'hb;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [2:0] START_MAJ = 3'h4;
  localparam logic [2:0] BIT_MAJ = 3'h2;
  localparam int SAMPLE_DIV_DEFAULT = 4;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } usf_req_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } usf_rx_state_t;
endpackage

// [hw/usf_core.sv]
// serial transceiver core with its eight status flags
// assumes synchronous rxd and a one-cycle strobe register master
`timescale 1ns/1ps
`default_nettype none
module usf_core #(
  parameter int unsigned SAMPLE_DIV = usf_pkg::SAMPLE_DIV_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire usf_pkg::usf_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic rxd,
  output logic txd
);
  //////////////////////////////////////////////////////////////////////
  // register decode
  logic acc_data_rd, acc_data_wr, acc_stat_rd, acc_stat_wr, acc_ctrl_wr;
  logic acc_ctrl_rd;
  logic [7:0] status, ctrl, arm, rx_data, rd_mux;
  logic [7:0] status_clr, status_set, next_status;
  assign acc_data_rd = bus_req.rd && bus_req.addr == usf_pkg::ADDR_DATA;
  assign acc_data_wr = bus_req.wr && bus_req.addr == usf_pkg::ADDR_DATA;
  assign acc_stat_rd = bus_req.rd && bus_req.addr == usf_pkg::ADDR_STATUS;
  assign acc_stat_wr = bus_req.wr && bus_req.addr == usf_pkg::ADDR_STATUS;
  assign acc_ctrl_wr = bus_req.wr && bus_req.addr == usf_pkg::ADDR_CTRL;
  assign acc_ctrl_rd = bus_req.rd && bus_req.addr == usf_pkg::ADDR_CTRL;
  assign rd_mux = acc_data_rd ? rx_data :
                  acc_stat_rd ? status :
                  acc_ctrl_rd ? ctrl : 8'h00;

  // enable rising or a break request also ends a finished period
  logic tc_alt_clr;
  assign tc_alt_clr = acc_ctrl_wr &&
    ((bus_req.wdata[usf_pkg::C_TXON] && !ctrl[usf_pkg::C_TXON]) ||
     bus_req.wdata[usf_pkg::C_BRK]);

  // clears need an armed flag from an earlier status read
  assign status_clr =
    (acc_data_wr ? (arm & usf_pkg::CLR_ON_WRITE) : 8'h00) |
    (acc_data_rd ? (arm & usf_pkg::CLR_ON_READ) : 8'h00) |
    (tc_alt_clr ? (arm & usf_pkg::CLR_TC) : 8'h00);
  // set wins over clear so no event is lost
  assign next_status = (status & ~status_clr) | status_set;

  // status writes land nowhere
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= usf_pkg::STATUS_RESET;
      ctrl <= usf_pkg::CTRL_RESET;
      arm <= 8'h00;
      bus_rdata <= 8'h00;
    end else begin
      status <= next_status;
      bus_rdata <= rd_mux;
      if (acc_ctrl_wr) begin
        ctrl <= bus_req.wdata;
      end
      if (acc_stat_rd) begin
        arm <= status | usf_pkg::ARM_ALWAYS;
      end else if (acc_data_rd || acc_data_wr) begin
        arm <= 8'h00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sample tick divider
  logic [15:0] div_cnt;
  logic tick;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt == 16'(SAMPLE_DIV - 1)) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // transmitter
  logic nine, pen, pkind;
  logic [3:0] char_len;
  assign nine = ctrl[usf_pkg::C_NINE];
  assign pen = ctrl[usf_pkg::C_PEN];
  assign pkind = ctrl[usf_pkg::C_PKIND];
  assign char_len = nine ? usf_pkg::CHAR_BITS_9 : usf_pkg::CHAR_BITS_8;

  logic [7:0] tx_buf;
  logic [10:0] tx_sh, tx_frame;
  logic [3:0] tx_left, tx_bcnt;
  logic tx_busy, pre_q, tx_par, tx_free, tx_bit_end, tx_finish;
  logic tx_load_brk, tx_load_pre, tx_load_data, tx_load, tx_done;
  logic tx_buffer_empty_flag_after;
  // even parity xors to zero over data plus parity bit
  assign tx_par = (nine ? ^tx_buf : ^tx_buf[6:0]) ^ pkind;
  assign tx_free = !tx_busy && ctrl[usf_pkg::C_TXON];
  assign tx_load_brk = tx_free && ctrl[usf_pkg::C_BRK];
  assign tx_load_pre = tx_free && !ctrl[usf_pkg::C_BRK] && pre_q;
  assign tx_load_data = tx_free && !ctrl[usf_pkg::C_BRK] && !pre_q &&
                        !status[usf_pkg::B_TX_BUFFER_EMPTY_FLAG];
  assign tx_load = tx_load_brk || tx_load_pre || tx_load_data;
  assign tx_frame = tx_load_brk ? 11'h000 :
                    tx_load_pre ? 11'h7ff :
                    nine ? {1'b1, pen ? tx_par : 1'b0, tx_buf, 1'b0} :
                    {2'b11, pen ? tx_par : tx_buf[7], tx_buf[6:0], 1'b0};
  assign tx_bit_end = tx_busy && tick && tx_bcnt == usf_pkg::LAST_TICK;
  assign tx_finish = tx_bit_end && tx_left == 4'h1;
  assign tx_buffer_empty_flag_after = status[usf_pkg::B_TX_BUFFER_EMPTY_FLAG] &&
                      !status_clr[usf_pkg::B_TX_BUFFER_EMPTY_FLAG];
  // nothing else queued, so the line really goes quiet
  assign tx_done = tx_finish && tx_buffer_empty_flag_after && !ctrl[usf_pkg::C_BRK] &&
                   !pre_q && !tc_alt_clr;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf <= 8'h00;
      tx_sh <= 11'h7ff;
      tx_left <= 4'h0;
      tx_bcnt <= 4'h0;
      tx_busy <= 1'b0;
      pre_q <= 1'b0;
      txd <= 1'b1;
    end else begin
      if (acc_data_wr) begin
        tx_buf <= bus_req.wdata;
      end
      if (acc_ctrl_wr && bus_req.wdata[usf_pkg::C_TXON] &&
          !ctrl[usf_pkg::C_TXON]) begin
        pre_q <= 1'b1;
      end else if (tx_load_pre) begin
        pre_q <= 1'b0;
      end
      if (tx_load) begin
        tx_sh <= tx_frame;
        tx_left <= char_len;
        tx_bcnt <= 4'h0;
        tx_busy <= 1'b1;
        txd <= tx_frame[0];
      end else if (tx_busy && tick) begin
        tx_bcnt <= tx_bcnt + 4'h1;
        if (tx_bit_end) begin
          tx_sh <= {1'b1, tx_sh[10:1]};
          tx_left <= tx_left - 4'h1;
          txd <= tx_finish ? 1'b1 : tx_sh[1];
          tx_busy <= !tx_finish;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receiver
  usf_pkg::usf_rx_state_t rx_st;
  logic [3:0] rx_cnt, rx_bits, idle_cnt;
  logic [2:0] rx_ones;
  logic [8:0] rx_sh;
  logic rx_ref, rx_noise, idle_pend;
  logic in_start, in_frame, samp, first_samp, bit_end, bit_val;
  logic rx_deliver, rx_accept, rx_buffer_full_flag_kept, par_bad, frame_bad, idle_set;
  logic long_break_detect_enable, idle_count_after_stop, last_data;
  logic [7:0] rx_byte;
  assign long_break_detect_enable = ctrl[usf_pkg::C_LONG_BREAK_DETECT_ENABLE];
  assign idle_count_after_stop = ctrl[usf_pkg::C_ILT];
  assign in_start = rx_st == usf_pkg::RX_START;
  assign in_frame = rx_st == usf_pkg::RX_DATA || rx_st == usf_pkg::RX_STOP;
  // seven samples in the start bit, three in the others
  assign samp = tick && (in_start ?
    (rx_cnt == usf_pkg::START_S_A || rx_cnt == usf_pkg::START_S_B ||
     (rx_cnt >= usf_pkg::DATA_S_FIRST &&
      rx_cnt <= usf_pkg::START_S_LAST)) :
    (in_frame && rx_cnt >= usf_pkg::DATA_S_FIRST &&
     rx_cnt <= usf_pkg::DATA_S_LAST));
  assign first_samp = in_start ? rx_cnt == usf_pkg::START_S_A :
                                 rx_cnt == usf_pkg::DATA_S_FIRST;
  // stop bit ends early so the next start edge is not missed
  assign bit_end = tick && (rx_st == usf_pkg::RX_STOP ?
    rx_cnt == usf_pkg::STOP_END :
    (in_frame || in_start) && rx_cnt == usf_pkg::LAST_TICK);
  assign bit_val = in_start ? rx_ones >= usf_pkg::START_MAJ :
                              rx_ones >= usf_pkg::BIT_MAJ;
  assign last_data = rx_bits == (nine ? usf_pkg::DATA_BITS_9 :
                                        usf_pkg::DATA_BITS_8) - 4'h1;
  assign rx_deliver = bit_end && rx_st == usf_pkg::RX_STOP;
  assign rx_buffer_full_flag_kept = status[usf_pkg::B_RX_BUFFER_FULL_FLAG] &&
                     !status_clr[usf_pkg::B_RX_BUFFER_FULL_FLAG];
  // long break mode swallows the character; only an overrun can still be flagged
  assign rx_accept = rx_deliver && !rx_buffer_full_flag_kept && !long_break_detect_enable;
  assign frame_bad = !bit_val;
  assign rx_byte = nine ? rx_sh[7:0] : rx_sh[8:1];
  assign par_bad = ((nine ? ^rx_sh : ^rx_sh[8:1]) != pkind);
  assign idle_set = idle_pend && idle_cnt >= char_len;

  assign status_set[usf_pkg::B_TX_BUFFER_EMPTY_FLAG] = tx_load_data;
  assign status_set[usf_pkg::B_TC] = tx_done;
  assign status_set[usf_pkg::B_RX_BUFFER_FULL_FLAG] = rx_accept;
  assign status_set[usf_pkg::B_IDLE] = idle_set;
  assign status_set[usf_pkg::B_OVR] = rx_deliver && rx_buffer_full_flag_kept;
  assign status_set[usf_pkg::B_NF] = rx_accept && rx_noise;
  assign status_set[usf_pkg::B_FE] = rx_accept && frame_bad;
  assign status_set[usf_pkg::B_PF] = rx_accept && pen && par_bad;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st <= usf_pkg::RX_IDLE;
      rx_cnt <= 4'h0;
      rx_bits <= 4'h0;
      rx_ones <= 3'h0;
      rx_ref <= 1'b1;
      rx_noise <= 1'b0;
      rx_sh <= 9'h000;
    end else begin
      if (tick) begin
        rx_cnt <= rx_cnt + 4'h1;
      end
      if (samp && first_samp) begin
        rx_ones <= {2'b00, rxd};
        rx_ref <= rxd;
      end else if (samp) begin
        rx_ones <= rx_ones + {2'b00, rxd};
        if (rxd != rx_ref) begin
          rx_noise <= 1'b1;
        end
      end
      case (rx_st)
        usf_pkg::RX_IDLE: begin
          if (!rxd) begin
            rx_st <= usf_pkg::RX_START;
            rx_cnt <= 4'h0;
            rx_noise <= 1'b0;
          end
        end
        usf_pkg::RX_START: begin
          if (bit_end) begin
            rx_st <= bit_val ? usf_pkg::RX_IDLE : usf_pkg::RX_DATA;
            rx_bits <= 4'h0;
          end
        end
        usf_pkg::RX_DATA: begin
          if (bit_end) begin
            rx_sh <= {bit_val, rx_sh[8:1]};
            rx_bits <= rx_bits + 4'h1;
            if (last_data) begin
              rx_st <= usf_pkg::RX_STOP;
            end
          end
        end
        usf_pkg::RX_STOP: begin
          if (bit_end) begin
            rx_st <= usf_pkg::RX_IDLE;
            rx_cnt <= 4'h0;
          end
        end
        default: begin
          rx_st <= usf_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // idle bit counter; saturates so a long quiet line cannot wrap
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt <= 4'h0;
      idle_pend <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      if (rx_accept) begin
        rx_data <= rx_byte;
      end
      if (rx_accept) begin
        idle_pend <= 1'b1;
      end else if (idle_set) begin
        idle_pend <= 1'b0;
      end
      if (rx_st == usf_pkg::RX_IDLE && !rxd) begin
        idle_cnt <= 4'h0;
      end else if (in_frame && bit_end) begin
        idle_cnt <= (!idle_count_after_stop && bit_val) ? idle_cnt + 4'h1 : 4'h0;
      end else if (rx_st == usf_pkg::RX_IDLE && tick &&
                   rx_cnt == usf_pkg::LAST_TICK && idle_cnt != 4'hf) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_tx_buffer_empty_flag_seen;
    acc_stat_rd && status[usf_pkg::B_TX_BUFFER_EMPTY_FLAG];
  endsequence
  // a character landing beside the read would carry unarmed flags
  sequence s_rx_buffer_full_flag_seen;
    acc_stat_rd && status[usf_pkg::B_RX_BUFFER_FULL_FLAG] && !rx_deliver;
  endsequence

  property p_ro;
    acc_stat_wr |=> (status & $past(status)) == $past(status);
  endproperty
  a_ro: assert property (p_ro) else $error("status write cleared a flag");
  // one quiet bus cycle between the two steps of the sequence
  property p_tx_buffer_empty_flag_clr;
    s_tx_buffer_empty_flag_seen ##1 (!acc_data_rd && !acc_data_wr) ##1 acc_data_wr |=>
      !status[usf_pkg::B_TX_BUFFER_EMPTY_FLAG];
  endproperty
  a_tx_buffer_empty_flag_clr: assert property (p_tx_buffer_empty_flag_clr) else $error("tx_buffer_empty_flag stuck");
  property p_rx_buffer_full_flag_clr;
    s_rx_buffer_full_flag_seen ##1 (!acc_data_rd && !acc_data_wr && !rx_deliver) ##1
      (acc_data_rd && !rx_deliver) |=> (status & 8'h2f) == 8'h00;
  endproperty
  a_rx_buffer_full_flag_clr: assert property (p_rx_buffer_full_flag_clr) else $error("rx flags kept");
  property p_ovr;
    rx_deliver && rx_buffer_full_flag_kept |=> status[usf_pkg::B_OVR] && $stable(rx_data);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missed");
  property p_lbk;
    rx_deliver && long_break_detect_enable && !status[usf_pkg::B_RX_BUFFER_FULL_FLAG] &&
      !status[usf_pkg::B_FE] |=>
      !status[usf_pkg::B_RX_BUFFER_FULL_FLAG] && !status[usf_pkg::B_FE];
  endproperty
  a_lbk: assert property (p_lbk) else $error("flag set in break mode");
  property p_tx_buffer_empty_flag_set;
    tx_load_data |=> status[usf_pkg::B_TX_BUFFER_EMPTY_FLAG] ##1 tx_busy;
  endproperty
  a_tx_buffer_empty_flag_set: assert property (p_tx_buffer_empty_flag_set) else $error("tx_buffer_empty_flag not set");
  property p_tc_clr;
    tc_alt_clr && arm[usf_pkg::B_TC] && !tx_done |=> !status[usf_pkg::B_TC];
  endproperty
  a_tc_clr: assert property (p_tc_clr) else $error("tc not cleared");
  property p_idle_once;
    $rose(status[usf_pkg::B_IDLE]) |->
      $past(idle_pend) && $past(idle_cnt) >= $past(char_len);
  endproperty
  a_idle_once: assert property (p_idle_once) else $error("bad idle");
  property p_noise;
    rx_accept && rx_noise |=>
      status[usf_pkg::B_NF] && status[usf_pkg::B_RX_BUFFER_FULL_FLAG];
  endproperty
  a_noise: assert property (p_noise) else $error("noise lost");
  property p_par;
    rx_accept && pen && par_bad |=> status[usf_pkg::B_PF];
  endproperty
  a_par: assert property (p_par) else $error("parity lost");
endmodule
`default_nettype wire

// [testbench/usf_remote_node.sv]
// remote serial node on the far side of the transceiver lines
// assumes 16 core_clk cycles per bit time (SAMPLE_DIV of 1)
`timescale 1ns/1ps
`default_nettype none
module usf_remote_node (
  input wire logic core_clk,
  output logic rxd,
  input wire logic txd,
  output logic [7:0] got_byte,
  output logic got_valid
);
  logic [7:0] cap;
  ////////////////////////////////////////
  // one frame, lsb first; a low stop lets go early so the line is not
  // mistaken for a new start bit
  task automatic send(input logic [7:0] d, input logic stop_hi,
      input logic glitch);
    logic [9:0] bits;
    bits = {stop_hi, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge core_clk);
        rxd <= (i == 9 && c >= 12) |
          (bits[i] ^ (glitch && i == 3 && c == 8));
      end
    end
  endtask
  ////////////////////////////////////////
  // frames ending in a low stop, breaks among them, are dropped
  initial begin
    rxd = 1'b1;
    got_byte = 8'h00;
    got_valid = 1'b0;
    forever begin
      @(negedge txd);
      repeat (8) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge core_clk);
        cap[i] = txd;
      end
      repeat (16) @(posedge core_clk);
      got_byte <= cap;
      got_valid <= txd;
      @(posedge core_clk);
      got_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench of the serial status flag block
// assumes the remote node model and a 125 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] A_DT = usf_pkg::ADDR_DATA;
  localparam logic [7:0] A_ST = usf_pkg::ADDR_STATUS;
  localparam logic [7:0] A_CT = usf_pkg::ADDR_CTRL;
  logic core_clk;
  logic rst_b;
  usf_pkg::usf_req_t bus_req;
  logic [7:0] bus_rdata;
  logic rxd;
  logic txd;
  logic [7:0] got_byte;
  logic got_valid;
  logic rd_seen;
  logic [7:0] exp_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] d0;
  logic [7:0] e_tx;
  int n_fail;
  int checks_done;
  usf_core #(.SAMPLE_DIV(1)) i_usf_core (.core_clk(core_clk),
    .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .rxd(rxd), .txd(txd));
  usf_remote_node i_usf_remote_node (.core_clk(core_clk), .rxd(rxd),
    .txd(txd), .got_byte(got_byte), .got_valid(got_valid));
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    $display("n_fail=%0d checks_done=%0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  // the expected value is queued before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    bus_req <= '0;
  endtask
  task automatic bits(input int n);
    repeat (n * 16) @(posedge core_clk);
  endtask
  // receive, check flags and data, then let the line idle and clear
  task automatic rx_case(input logic [7:0] ctrl, input logic [7:0] d,
      input logic two, input logic stop_hi, input logic glitch,
      input int wb, input logic [7:0] es, input logic [7:0] ed);
    wr(A_CT, ctrl);
    i_usf_remote_node.send(d, stop_hi, glitch);
    if (two) i_usf_remote_node.send(~d, 1'b1, 1'b0);
    bits(wb);
    rd(A_ST, es);
    rd(A_DT, ed);
    bits(12);
    rd(A_ST, 8'hc0 | ((es[5] && !es[4]) ? 8'h10 : 8'h00));
    rd(A_DT, ed);
  endtask
  ////////////////////////////////////////
  always @(posedge core_clk) begin
    rd_seen <= bus_req.rd;
    if (rd_seen === 1'b1) begin
      checks_done++;
      if (bus_rdata !== exp_q[0]) begin
        n_fail++;
        $display("ERROR bus_rdata expected %h seen %h", exp_q[0],
          bus_rdata);
      end
      void'(exp_q.pop_front());
    end
    if (got_valid === 1'b1) begin
      checks_done++;
      e_tx = tx_q.pop_front();
      if (got_byte !== e_tx) begin
        n_fail++;
        $display("ERROR txd byte expected %h seen %h", e_tx, got_byte);
      end
    end
  end
  // whole run is near 5500 cycles, so this leaves a wide margin
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    $display("ERROR watchdog expected end seen hang");
    report_and_stop();
  end
  ////////////////////////////////////////
  initial begin
    n_fail = 0;
    checks_done = 0;
    bus_req = '0;
    rst_b = 1'b0;
    void'($urandom(40));
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(A_ST, usf_pkg::STATUS_RESET);
    wr(A_ST, 8'h00);
    rd(A_ST, 8'hc0);
    rd(8'h7f, 8'h00);
    rd(A_DT, 8'h00);
    wr(A_CT, 8'h02);
    repeat (4) @(posedge core_clk);
    rd(A_ST, 8'hc0);
    bits(12);
    rd(A_ST, 8'hc0);
    wr(A_CT, 8'h00);
    rd(A_ST, 8'hc0);
    wr(A_CT, 8'h02);
    repeat (4) @(posedge core_clk);
    rd(A_ST, 8'h80);
    bits(12);
    rd(A_ST, 8'hc0);
    wr(A_CT, 8'h03);
    repeat (4) @(posedge core_clk);
    rd(A_ST, 8'h80);
    wr(A_CT, 8'h02);
    bits(25);
    d0 = $urandom;
    tx_q.push_back(d0);
    tx_q.push_back(~d0);
    rd(A_ST, 8'hc0);
    wr(A_DT, d0);
    repeat (4) @(posedge core_clk);
    rd(A_ST, 8'h80);
    wr(A_DT, ~d0);
    repeat (4) @(posedge core_clk);
    rd(A_ST, 8'h00);
    bits(11);
    rd(A_ST, 8'h80);
    bits(11);
    rd(A_ST, 8'hc0);
    d0 = $urandom;
    rx_case(8'h02, d0, 0, 1, 0, 0, 8'he0, d0);
    rx_case(8'h02, 8'hff, 0, 1, 0, 3, 8'hf0, 8'hff);
    rx_case(8'h12, 8'hff, 0, 1, 0, 3, 8'he0, 8'hff);
    d0 = $urandom;
    rx_case(8'h02, d0, 1, 1, 0, 0, 8'he8, d0);
    d0 = $urandom;
    rx_case(8'h02, d0, 0, 1, 1, 0, 8'he4, d0);
    d0 = $urandom;
    rx_case(8'h02, d0, 0, 0, 0, 0, 8'he2, d0);
    for (int k = 0; k < 2; k++) begin
      for (int b = 0; b < 2; b++) begin
        d0 = $urandom;
        d0[7] = ^d0[6:0] ^ k[0] ^ b[0];
        rx_case(8'h0a | 8'(k << 2), d0, 0, 1, 0, 0, 8'he0 | 8'(b),
          d0);
      end
    end
    rx_case(8'h42, ~d0, 0, 0, 0, 0, 8'hc0, d0);
    repeat (4) @(posedge core_clk);
    if (exp_q.size() != 0 || tx_q.size() != 0) begin
      n_fail++;
      $display("ERROR queues expected 0 seen %0d", exp_q.size());
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
